//--- rtl/pie_bank2.sv
// second peripheral interrupt enable bank with flags and request gating
// assumes an ahb-lite master on core_clk_i and event pulses from logic
// on the same clock, so the events pass no synchroniser

module pie_bank2 (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // source events, one bit per enable position
    input  wire logic [7:0]  src_evt_i,
    // gated requests
    output logic      [7:0]  periph_req_o,
    output logic             irq_o
);

    // ************************************************************
    // bus slave state
    // ************************************************************
    logic                    wr_pend_q;
    logic                    wr_pend_d;
    logic [11:0]             wr_addr_q;
    logic [11:0]             wr_addr_d;
    logic [31:0]             hrdata_q;
    logic [31:0]             hrdata_d;
    logic                    hready_q;
    logic                    hresp_q;
    logic                    addr_ok;

    // ************************************************************
    // register state
    // ************************************************************
    logic [7:0]              enable_q;
    logic [7:0]              enable_d;
    logic [7:0]              ctrl_q;
    logic [7:0]              ctrl_d;
    logic [7:0]              flag_q;
    logic [7:0]              flag_d;
    logic [7:0]              req_q;
    logic [7:0]              req_d;
    logic                    irq_q;
    logic                    irq_d;
    logic [7:0]              wbyte;

    assign wbyte = hwdata_i[7:0];

    // address phase taken when selected, ready and a real transfer
    assign addr_ok = hsel_i && hready_i
                     && (htrans_i == pie_pkg::HTRANS_NONSEQ
                         || htrans_i == pie_pkg::HTRANS_SEQ);

    // ************************************************************
    // register next values
    // ************************************************************
    // writes land in the data phase, when hwdata is valid
    always_comb begin
        enable_d = enable_q;
        ctrl_d   = ctrl_q;
        flag_d   = flag_q;
        if (wr_pend_q && wr_addr_q == pie_pkg::OFS_ENABLE) begin
            enable_d = wbyte & pie_pkg::IMPL_MASK;
        end
        if (wr_pend_q && wr_addr_q == pie_pkg::OFS_CTRL) begin
            ctrl_d = wbyte & pie_pkg::CTRL_MASK;
        end
        // write one clears, but a new event in the same cycle wins
        if (wr_pend_q && wr_addr_q == pie_pkg::OFS_FLAG) begin
            flag_d = flag_q & ~wbyte;
        end
        flag_d = (flag_d | src_evt_i) & pie_pkg::IMPL_MASK;
    end

    // ************************************************************
    // request gating, one gate per enable position
    // ************************************************************
    // gated from the registered state so every output is one flop deep
    for (genvar i = 0; i < pie_pkg::REG_W; i++) begin : g_gate
        assign req_d[i] = flag_q[i] && enable_q[i]
                          && ctrl_q[pie_pkg::BIT_PERIPH_IE];
    end

    // global enable sits on top of the peripheral one
    assign irq_d = (|req_d) && ctrl_q[pie_pkg::BIT_GLOBAL_IE];

    // ************************************************************
    // bus next values
    // ************************************************************
    // read data of enable, ctrl and flag uses next values so a read
    // right behind a write returns the freshly written contents
    always_comb begin
        wr_pend_d = addr_ok && hwrite_i;
        wr_addr_d = addr_ok ? haddr_i[11:0] : wr_addr_q;
        hrdata_d  = pie_pkg::RDATA_RST;
        if (addr_ok && !hwrite_i) begin
            case (haddr_i[11:0])
                pie_pkg::OFS_ENABLE: hrdata_d[7:0] = enable_d;
                pie_pkg::OFS_CTRL:   hrdata_d[7:0] = ctrl_d;
                pie_pkg::OFS_FLAG:   hrdata_d[7:0] = flag_d;
                pie_pkg::OFS_REQ:    hrdata_d[7:0] = req_q;
                default:             hrdata_d      = pie_pkg::RDATA_RST;
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // one synchronous reset covers power-on, brown-out and the rest
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            enable_q  <= pie_pkg::ENABLE_RST;
            ctrl_q    <= pie_pkg::CTRL_RST;
            flag_q    <= pie_pkg::FLAG_RST;
            req_q     <= pie_pkg::FLAG_RST;
            irq_q     <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= pie_pkg::OFS_ENABLE;
            hrdata_q  <= pie_pkg::RDATA_RST;
            hready_q  <= 1'b1;
            hresp_q   <= pie_pkg::HRESP_OKAY;
        end else begin
            enable_q  <= enable_d;
            ctrl_q    <= ctrl_d;
            flag_q    <= flag_d;
            req_q     <= req_d;
            irq_q     <= irq_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q  <= hrdata_d;
            hready_q  <= 1'b1; // zero wait states, never stalls
            hresp_q   <= pie_pkg::HRESP_OKAY;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign hrdata_o     = hrdata_q;
    assign hreadyout_o  = hready_q;
    assign hresp_o      = hresp_q; // always okay, kept in a flop
    assign periph_req_o = req_q;
    assign irq_o        = irq_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // a write to the enable bank: address phase then data phase
    sequence s_enable_write;
        addr_ok && hwrite_i && haddr_i[11:0] == pie_pkg::OFS_ENABLE
        ##1 1'b1;
    endsequence

    // a read of the enable bank
    sequence s_enable_read;
        addr_ok && !hwrite_i && haddr_i[11:0] == pie_pkg::OFS_ENABLE;
    endsequence

    a_periph_ie_block: assert property (
        !ctrl_q[pie_pkg::BIT_PERIPH_IE] |=> periph_req_o == 8'h00
                                            && !irq_o)
        else $error("request passed with peripheral enable clear");

    a_osc_fail_gate: assert property (
        periph_req_o[pie_pkg::BIT_OSC_FAIL] ==
        ($past(flag_q[pie_pkg::BIT_OSC_FAIL])
         && $past(enable_q[pie_pkg::BIT_OSC_FAIL])
         && $past(ctrl_q[pie_pkg::BIT_PERIPH_IE])))
        else $error("oscillator fail request mis-gated");

    a_cmp_two_gate: assert property (
        (flag_q[pie_pkg::BIT_CMP_TWO] && ctrl_q[pie_pkg::BIT_PERIPH_IE])
        |=> periph_req_o[pie_pkg::BIT_CMP_TWO]
            == $past(enable_q[pie_pkg::BIT_CMP_TWO]))
        else $error("second comparator request mis-gated");

    a_cmp_one_gate: assert property (
        !enable_q[pie_pkg::BIT_CMP_ONE]
        |=> !periph_req_o[pie_pkg::BIT_CMP_ONE])
        else $error("first comparator request passed while disabled");

    a_nvm_done_gate: assert property (
        (src_evt_i[pie_pkg::BIT_NVM_DONE]
         && enable_q[pie_pkg::BIT_NVM_DONE]
         && ctrl_q[pie_pkg::BIT_PERIPH_IE]) ##1
        (enable_q[pie_pkg::BIT_NVM_DONE]
         && ctrl_q[pie_pkg::BIT_PERIPH_IE])
        |=> periph_req_o[pie_pkg::BIT_NVM_DONE])
        else $error("memory write done request lost");

    a_bus_coll_gate: assert property (
        periph_req_o[pie_pkg::BIT_BUS_COLL]
        |-> $past(enable_q[pie_pkg::BIT_BUS_COLL])
            && $past(flag_q[pie_pkg::BIT_BUS_COLL]))
        else $error("bus collision request without enable");

    a_unused_bit_zero: assert property (
        s_enable_read |=> hrdata_o[pie_pkg::BIT_UNUSED] == 1'b0
                          && !enable_q[pie_pkg::BIT_UNUSED])
        else $error("unimplemented enable bit not zero");

    a_enable_write: assert property (
        s_enable_write |=> enable_q
                           == ($past(hwdata_i[7:0]) & pie_pkg::IMPL_MASK))
        else $error("enable bank write not stored");

    a_enable_reset: assert property (
        disable iff (1'b0)
        rst_i |=> enable_q == pie_pkg::ENABLE_RST && !irq_o)
        else $error("enable bank not cleared by reset");

    a_lcd_capcomp_gate: assert property (
        (!enable_q[pie_pkg::BIT_LCD] && !enable_q[pie_pkg::BIT_CAPCOMP_2])
        |=> !periph_req_o[pie_pkg::BIT_LCD]
            && !periph_req_o[pie_pkg::BIT_CAPCOMP_2])
        else $error("lcd or capture request passed while disabled");

    a_core_irq_path: assert property (
        irq_o == (|($past(flag_q) & $past(enable_q))
                  && $past(ctrl_q[pie_pkg::BIT_PERIPH_IE])
                  && $past(ctrl_q[pie_pkg::BIT_GLOBAL_IE])))
        else $error("core interrupt not the and of all enables");

    // a write to the core interrupt control copy
    sequence s_ctrl_write;
        addr_ok && hwrite_i && haddr_i[11:0] == pie_pkg::OFS_CTRL
        ##1 1'b1;
    endsequence

    // global and peripheral enables stored, other bits dropped
    a_ctrl_write: assert property (
        s_ctrl_write |=> ctrl_q
                         == ($past(hwdata_i[7:0]) & pie_pkg::CTRL_MASK))
        else $error("interrupt control write not stored");

    // with the peripheral enable set a pending source must show
    a_periph_ie_pass: assert property (
        (ctrl_q[pie_pkg::BIT_PERIPH_IE] && |(flag_q & enable_q))
        |=> periph_req_o != 8'h00)
        else $error("enabled request held back");

    // the missing bit stays clear in every copy of the bank
    a_unused_never_set: assert property (
        !enable_q[pie_pkg::BIT_UNUSED] && !flag_q[pie_pkg::BIT_UNUSED]
        && !periph_req_o[pie_pkg::BIT_UNUSED])
        else $error("unimplemented bit set");

    // only a data phase aimed at the bank may change it
    a_enable_hold: assert property (
        !(wr_pend_q && wr_addr_q == pie_pkg::OFS_ENABLE)
        |=> $stable(enable_q))
        else $error("enable bank changed without a write");

    // read data of the bank matches what the bank holds next
    a_enable_readback: assert property (
        s_enable_read |=> hrdata_o == {24'h00_0000, enable_q})
        else $error("enable bank read data wrong");

    // zero wait states and never an error response
    a_bus_always_ready: assert property (
        hreadyout_o && hresp_o == pie_pkg::HRESP_OKAY)
        else $error("bus slave stalled or answered an error");

    // a request is never raised for a source whose flag was clear
    a_req_needs_flag: assert property (
        (periph_req_o & ~$past(flag_q)) == 8'h00)
        else $error("request raised without its flag");

    // the core line stays low while the global enable is clear
    a_irq_needs_global: assert property (
        irq_o |-> $past(ctrl_q[pie_pkg::BIT_GLOBAL_IE]))
        else $error("core interrupt raised with global enable clear");

    // write one clears a flag, unless its source fires again
    a_flag_clear: assert property (
        (wr_pend_q && wr_addr_q == pie_pkg::OFS_FLAG)
        |=> (flag_q & $past(wbyte) & ~$past(src_evt_i)) == 8'h00)
        else $error("flag not cleared by a write of one");

    // set beats clear: an event is never lost to a clear in
    // the same cycle, so software cannot miss a source
    a_flag_set_wins: assert property (
        (|(src_evt_i & pie_pkg::IMPL_MASK))
        |=> (flag_q & $past(src_evt_i) & pie_pkg::IMPL_MASK)
            == ($past(src_evt_i) & pie_pkg::IMPL_MASK))
        else $error("event lost against a flag clear");

endmodule : pie_bank2

//--- rtl/pie_pkg.sv
// constants for the second peripheral interrupt enable bank
// assumes a 32-bit ahb-lite slave port and single-clock integration

package pie_pkg;

    // ************************************************************
    // bus widths
    // ************************************************************
    localparam int          DATA_W   = 32;
    localparam int          ADDR_W   = 32;
    localparam int          DEC_W    = 12;   // decoded low address bits
    localparam int          REG_W    = 8;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [11:0] OFS_ENABLE = 12'h000; // enable bank
    localparam logic [11:0] OFS_CTRL   = 12'h004; // core interrupt control
    localparam logic [11:0] OFS_FLAG   = 12'h008; // sticky source flags
    localparam logic [11:0] OFS_REQ    = 12'h00C; // gated requests, ro

    // ************************************************************
    // enable bank bit positions
    // ************************************************************
    localparam int          BIT_OSC_FAIL  = 7;
    localparam int          BIT_CMP_TWO   = 6;
    localparam int          BIT_CMP_ONE   = 5;
    localparam int          BIT_NVM_DONE  = 4;
    localparam int          BIT_BUS_COLL  = 3;
    localparam int          BIT_LCD       = 2;
    localparam int          BIT_UNUSED    = 1;
    localparam int          BIT_CAPCOMP_2 = 0;

    // implemented bits of the bank; bit 1 is absent
    localparam logic [7:0]  IMPL_MASK  = 8'hFD;
    localparam logic [7:0]  ENABLE_RST = 8'h00;
    localparam logic [7:0]  FLAG_RST   = 8'h00;

    // ************************************************************
    // core interrupt control layout
    // ************************************************************
    localparam int          BIT_GLOBAL_IE = 7;
    localparam int          BIT_PERIPH_IE = 6;
    localparam logic [7:0]  CTRL_MASK     = 8'hC0;
    localparam logic [7:0]  CTRL_RST      = 8'h00;

    // ************************************************************
    // ahb-lite encodings
    // ************************************************************
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
    localparam logic        HRESP_OKAY    = 1'h0;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

endpackage : pie_pkg

//--- test/pie_bank2_tb.sv
// self-checking bench for the second peripheral interrupt enable bank
// assumes the one slave's hreadyout is the bus ready and a 20 MHz clock

module pie_bank2_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic        core_clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  src_evt;
    logic [7:0]  periph_req;
    logic        irq;
    int          fails       = 0;
    int          comparisons = 0;
    logic [31:0] rd;

    // single slave: its ready is the bus ready
    pie_bank2 i_dut (
        .core_clk_i  (core_clk),   .rst_i        (rst),
        .hsel_i      (hsel),       .haddr_i      (haddr),
        .htrans_i    (htrans),     .hwrite_i     (hwrite),
        .hsize_i     (3'h2),       .hwdata_i     (hwdata),
        .hready_i    (hreadyout),  .hrdata_o     (hrdata),
        .hreadyout_o (hreadyout),  .hresp_o      (hresp),
        .src_evt_i   (src_evt),    .periph_req_o (periph_req),
        .irq_o       (irq)
    );

    // 50 ns period
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ************************************************************
    // compare, bus and event tasks
    // ************************************************************
    task automatic chk_word(input string n, input logic [31:0] e,
                            input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string n, input logic e, input logic g);
        chk_word(n, {31'h0, e}, {31'h0, g});
    endtask : chk_bit

    // address phase held until ready, then data phase until ready
    task automatic bus_xfer(input logic [11:0] a, input logic w,
                            input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, a};
        hwrite <= w;
        htrans <= pie_pkg::HTRANS_NONSEQ;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk_bit("hresp", pie_pkg::HRESP_OKAY, hresp);
    endtask : bus_xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus_xfer(a, 1'b1, d, unused);
    endtask : wr

    task automatic rd_chk(input string n, input logic [11:0] a,
                          input logic [31:0] e);
        logic [31:0] q;
        bus_xfer(a, 1'b0, 32'h0000_0000, q);
        chk_word(n, e, q);
    endtask : rd_chk

    // one-cycle event pulse, then let flag and request settle
    task automatic pulse(input logic [7:0] v);
        src_evt <= v;
        @(posedge core_clk);
        src_evt <= 8'h00;
        repeat (3) @(posedge core_clk);
    endtask : pulse

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        rd_chk("enable", pie_pkg::OFS_ENABLE, 32'h0000_0000);
        rd_chk("ctrl", pie_pkg::OFS_CTRL, 32'h0000_0000);
        rd_chk("flag", pie_pkg::OFS_FLAG, 32'h0000_0000);
        chk_bit("irq", 1'b0, irq);
        chk_word("req", 32'h0000_0000, {24'h00_0000, periph_req});
        $display("test reset done");
    endtask : t_reset

    task automatic t_access;
        wr(pie_pkg::OFS_ENABLE, 32'h0000_00ff);
        rd_chk("enable", pie_pkg::OFS_ENABLE, 32'h0000_00fd);
        wr(pie_pkg::OFS_ENABLE, 32'h0000_0002);
        rd_chk("enable", pie_pkg::OFS_ENABLE, 32'h0000_0000);
        // unmapped place reads zero and ignores writes
        wr(12'h010, 32'h0000_00ff);
        rd_chk("unmapped", 12'h010, 32'h0000_0000);
        rd_chk("enable", pie_pkg::OFS_ENABLE, 32'h0000_0000);
        $display("test access done");
    endtask : t_access

    // each enable passes only its own source; global enable still off
    task automatic t_gating;
        int bits [7] = '{7, 6, 5, 4, 3, 2, 0};
        wr(pie_pkg::OFS_CTRL, 32'h0000_0040);
        foreach (bits[k]) begin
            wr(pie_pkg::OFS_ENABLE, 32'h0000_0001 << bits[k]);
            pulse(8'hff);
            chk_word("req", 32'h0000_0001 << bits[k],
                     {24'h00_0000, periph_req});
            chk_bit("irq", 1'b0, irq);
            rd_chk("flag", pie_pkg::OFS_FLAG, 32'h0000_00fd);
            wr(pie_pkg::OFS_FLAG, 32'h0000_00ff);
            repeat (2) @(posedge core_clk);
            chk_word("req", 32'h0, {24'h0, periph_req});
        end
        $display("test gating done");
    endtask : t_gating

    // raise, mask and clear the interrupt line
    task automatic t_global;
        wr(pie_pkg::OFS_CTRL, 32'h0000_0000);
        wr(pie_pkg::OFS_ENABLE, 32'h0000_00fd);
        pulse(8'hff);
        chk_word("req", 32'h0, {24'h0, periph_req});
        wr(pie_pkg::OFS_CTRL, 32'h0000_0080);
        repeat (2) @(posedge core_clk);
        chk_bit("irq", 1'b0, irq);
        wr(pie_pkg::OFS_CTRL, 32'h0000_00c0);
        repeat (2) @(posedge core_clk);
        chk_word("req", 32'hfd, {24'h0, periph_req});
        chk_bit("irq", 1'b1, irq);
        wr(pie_pkg::OFS_ENABLE, 32'h0000_0000);
        repeat (2) @(posedge core_clk);
        chk_bit("irq", 1'b0, irq);
        wr(pie_pkg::OFS_FLAG, 32'h0000_00ff);
        wr(pie_pkg::OFS_ENABLE, 32'h0000_00fd);
        repeat (2) @(posedge core_clk);
        chk_bit("irq", 1'b0, irq);
        $display("test global done");
    endtask : t_global

    // an event in the data phase of a flag clear keeps its flag
    task automatic t_race;
        pulse(8'hff);
        fork
            wr(pie_pkg::OFS_FLAG, 32'h0000_00ff);
            begin
                @(posedge core_clk);
                src_evt <= 8'h80;
                @(posedge core_clk);
                src_evt <= 8'h00;
            end
        join
        rd_chk("flag", pie_pkg::OFS_FLAG, 32'h0000_0080);
        chk_word("req", 32'h0000_0080, {24'h00_0000, periph_req});
        chk_bit("irq", 1'b1, irq);
        $display("test set over clear done");
    endtask : t_race

    // a reset in mid-run clears bank, flags and requests again
    task automatic t_rerst;
        pulse(8'hff);
        chk_bit("irq", 1'b1, irq);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd_chk("enable", pie_pkg::OFS_ENABLE, 32'h0000_0000);
        rd_chk("ctrl", pie_pkg::OFS_CTRL, 32'h0000_0000);
        rd_chk("flag", pie_pkg::OFS_FLAG, 32'h0000_0000);
        chk_word("req", 32'h0000_0000, {24'h00_0000, periph_req});
        chk_bit("irq", 1'b0, irq);
        $display("test second reset done");
    endtask : t_rerst

    // ************************************************************
    // verdict, watchdog and main sequence
    // ************************************************************
    task automatic test_done;
        $display("checks %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        test_done();
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        src_evt = 8'h00;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_access();
        t_gating();
        t_global();
        t_race();
        t_rerst();
        test_done();
    end
endmodule : pie_bank2_tb
